/* verilog/adcsc_top.sv */
`timescale 1ns/1ps
// What this block does
// - Writing the control register aborts any sequence and restarts it anew.
// - Control bit 7 picks left (0) or right (1) result alignment.
// - Control bit 6 picks unsigned (0) or two's complement signed (1).
// - Right justified results are always unsigned.
// - Control bit 5 picks one sequence (0) or continuous scanning (1).
// - With bit 4 clear every conversion uses the selected channel.
// - Multi-channel runs start at the code and step once per conversion.
// - The stepped channel code wraps from seven back to zero.
// - Channel code n selects analog input n, zero to seven.
// - Eight bit left results sit in bits 15 down to 8.
// - Eight bit right results sit in bits 7 down to 0.
// - Ten bit left results sit in bits 15 down to 6.
// - Ten bit right results sit in bits 9 down to 0.
// - Signed left results are the unsigned code with the top bit flipped.
// - The control register is readable and writable at any time.
// - A resolution bit picks ten bits (0) or eight bits (1).
// - A control register write clears the sequence complete flag.
module adcsc_top import adcsc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter side
  output logic conv_start,
  output logic [CH_W-1:0] conv_chan,
  input wire logic conv_done,
  input wire logic [RAW_W-1:0] conv_data,
  // Interrupt
  output logic irq
);

  // ***********************************************************
  // Bus decode
  // ***********************************************************

  logic [7:0] ctl_q;
  logic [7:0] cfg_q;
  logic [EV_W-1:0] stat_q;
  logic [EV_W-1:0] ien_q;
  logic [EV_W-1:0] clr;
  logic [EV_W-1:0] ev;
  logic irq_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic setup;
  logic wr_fire;
  logic wr_ctl;
  logic mapped;
  logic [31:0] rd_val;
  logic [RES_W-1:0] result_q;
  logic [CH_W-1:0] chan_q;
  logic conv_start_q;

  adcsc_seq_if sif ();

  // Address match against one register index
  function automatic logic hit(input logic [7:0] addr,
    input logic [7:0] idx);
    hit = (addr == adcsc_addr(idx));
  endfunction

  // Phases of an APB transfer
  assign setup = psel && !penable;
  assign wr_fire = psel && penable && pready_q && pwrite;
  assign wr_ctl = wr_fire && hit(paddr, IDX_CTL);
  assign mapped = hit(paddr, IDX_CFG) || hit(paddr, IDX_CTL) ||
    hit(paddr, IDX_STAT) || hit(paddr, IDX_ICLR) ||
    hit(paddr, IDX_IEN) || hit(paddr, IDX_RES);

  // ***********************************************************
  // Registers
  // ***********************************************************

  // Sequence control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= CTL_RST;
    end else if (wr_ctl) begin
      ctl_q <= pwdata[7:0] & CTL_WMASK;
    end
  end

  // Configuration: resolution and sequence length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RST;
    end else if (wr_fire && hit(paddr, IDX_CFG)) begin
      cfg_q <= pwdata[7:0] & CFG_WMASK;
    end
  end

  // Interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= '0;
    end else if (wr_fire && hit(paddr, IDX_IEN)) begin
      ien_q <= pwdata[EV_W-1:0];
    end
  end

  // Sticky events; a set in the clearing cycle wins
  assign ev = {sif.conv_ev, sif.seq_ev};
  always_comb begin
    clr = '0;
    if (wr_fire && hit(paddr, IDX_ICLR)) begin
      clr = pwdata[EV_W-1:0];
    end
    if (wr_ctl) begin
      clr[EV_SEQ] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr) | ev;
    end
  end

  // Level interrupt from enabled status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & ien_q);
    end
  end

  // ***********************************************************
  // Read path and APB answer
  // ***********************************************************

  // Read mux; write-only and unmapped words read zero
  always_comb begin
    rd_val = '0;
    if (hit(paddr, IDX_CTL)) begin
      rd_val[7:0] = ctl_q;
    end else if (hit(paddr, IDX_CFG)) begin
      rd_val[7:0] = cfg_q;
    end else if (hit(paddr, IDX_STAT)) begin
      rd_val[EV_W-1:0] = stat_q;
      rd_val[STAT_CH_LSB +: CH_W] = chan_q;
      rd_val[STAT_BUSY] = sif.busy;
    end else if (hit(paddr, IDX_IEN)) begin
      rd_val[EV_W-1:0] = ien_q;
    end else if (hit(paddr, IDX_RES)) begin
      rd_val[RES_W-1:0] = result_q;
    end
  end

  // One access cycle, answered from the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q <= (setup && !pwrite) ? rd_val : '0;
    end
  end

  // ***********************************************************
  // Sequencer and formatter
  // ***********************************************************

  // New settings take effect in the restart cycle
  assign sif.restart = wr_ctl;
  assign sif.first_chan = wr_ctl ? pwdata[CH_W-1:0] : ctl_q[CH_W-1:0];
  assign sif.multi_channel_sample = ctl_q[CTL_MULTI_CHANNEL_SAMPLE];
  assign sif.scan = ctl_q[CTL_SCAN];
  assign sif.seq_len = cfg_q[SEQ_W-1:0];

  adcsc_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .sif(sif),
    .conv_done(conv_done),
    .conv_start_q(conv_start_q),
    .chan_q(chan_q)
  );

  adcsc_fmt u_fmt (
    .pclk(pclk),
    .presetn(presetn),
    .cap(sif.conv_ev),
    .raw(conv_data),
    .res8(cfg_q[CFG_RES8]),
    .justify(ctl_q[CTL_JUST]),
    .signed_sel(ctl_q[CTL_SIGN]),
    .result_q(result_q)
  );

  // Outputs straight from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign conv_start = conv_start_q;
  assign conv_chan = chan_q;
  assign irq = irq_q;

  // ***********************************************************
  // Checks
  // ***********************************************************

  ctl_restart_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctl ##1 !wr_ctl |=> conv_start && conv_chan ==
    $past(pwdata[CH_W-1:0], 2))
    else $error("control write did not restart");
  rsvd_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctl_q[CTL_RSVD] == 1'b0)
    else $error("reserved control bit set");
  flag_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctl && !sif.seq_ev |=> !stat_q[EV_SEQ])
    else $error("complete flag survived control write");
  ctl_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctl |=> ctl_q == ($past(pwdata[7:0]) & CTL_WMASK))
    else $error("control write lost");
  seq_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    sif.seq_ev |=> stat_q[EV_SEQ] ##1 irq == (|$past(ien_q)))
    else $error("sequence event not flagged");
  single_run_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    sif.seq_ev && !sif.scan && !sif.restart |=> !sif.busy)
    else $error("single run kept going");

  restart_c: cover property (@(posedge pclk) disable iff (!presetn)
    sif.busy && wr_ctl);
  scan_c: cover property (@(posedge pclk) disable iff (!presetn)
    sif.seq_ev && sif.scan && sif.multi_channel_sample);
  wrap_c: cover property (@(posedge pclk) disable iff (!presetn)
    conv_start && conv_chan == '1 ##[1:40] conv_start && conv_chan == '0);
  signed_c: cover property (@(posedge pclk) disable iff (!presetn)
    sif.conv_ev && ctl_q[CTL_SIGN] && !ctl_q[CTL_JUST]);
  bus_err_c: cover property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr);

  // ***********************************************************
  // Bus answer checks
  // ***********************************************************

  // Ready stands for one cycle only
  ready_once_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  // Every setup is answered in the next cycle
  ready_next_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("no ready after setup");
  // Error only comes together with ready
  err_ready_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
  // Unmapped words are refused
  unmapped_err_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !mapped |=> pslverr)
    else $error("unmapped access not refused");
  // Read data is zero outside an answer
  rdata_idle_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == '0)
    else $error("read data outside answer");
  // Control register reads back with bit 3 clear
  ctl_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit(paddr, IDX_CTL) |=>
    prdata[CTL_JUST:0] == $past(ctl_q) && !prdata[CTL_RSVD])
    else $error("control read wrong");

  // ***********************************************************
  // Result and sequence checks
  // ***********************************************************

  // Eight bit right results fill the low byte only
  right_eight_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    sif.conv_ev && ctl_q[CTL_JUST] && cfg_q[CFG_RES8] |=>
    result_q == RES_W'($past(conv_data[RAW_W-1:RAW_W-C8_W])))
    else $error("eight bit right result misplaced");
  // Ten bit right results are the raw code
  right_ten_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    sif.conv_ev && ctl_q[CTL_JUST] && !cfg_q[CFG_RES8] |=>
    result_q == RES_W'($past(conv_data)))
    else $error("ten bit right result misplaced");
  // Eight bit left results fill the high byte only
  left_eight_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    sif.conv_ev && !ctl_q[CTL_JUST] && cfg_q[CFG_RES8] |=>
    result_q[RES_W-C8_W-1:0] == '0 && result_q[RES_W-2:RES_W-C8_W] ==
    $past(conv_data[RAW_W-2:RAW_W-C8_W]))
    else $error("eight bit left result misplaced");
  // Ten bit left results carry the code below the top bit
  left_body_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    sif.conv_ev && !ctl_q[CTL_JUST] && !cfg_q[CFG_RES8] |=>
    result_q[RES_W-2:RES_W-RAW_W] == $past(conv_data[RAW_W-2:0]))
    else $error("ten bit left code misplaced");
  // Result only changes on a finished conversion
  hold_result_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !sif.conv_ev |=> $stable(result_q))
    else $error("result changed without conversion");
  // Start strobe is a single cycle pulse
  start_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_start |=> !conv_start)
    else $error("start held too long");
  // No start while the sequencer rests
  idle_quiet_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !sif.busy |=> !conv_start)
    else $error("start while idle");
  // A control write always wakes the sequencer
  restart_busy_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctl |=> sif.busy)
    else $error("control write left sequencer idle");
  // Each finished conversion raises its flag
  conv_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    sif.conv_ev |=> stat_q[EV_CONV])
    else $error("conversion event not flagged");
  // Interrupt follows enabled status one cycle later
  irq_level_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq == (|($past(stat_q) & $past(ien_q))))
    else $error("interrupt level wrong");

endmodule

/* verilog/adcsc_pkg.sv */
package adcsc_pkg;

  // ***********************************************************
  // Register indices (byte address is four times the index)
  // ***********************************************************
  localparam logic [7:0] IDX_CFG = 8'h04;
  localparam logic [7:0] IDX_CTL = 8'h05;
  localparam logic [7:0] IDX_STAT = 8'h06;
  localparam logic [7:0] IDX_ICLR = 8'h07;
  localparam logic [7:0] IDX_IEN = 8'h08;
  localparam logic [7:0] IDX_RES = 8'h09;

  // ***********************************************************
  // Field layouts and reset values
  // ***********************************************************
  localparam int CTL_JUST = 7;
  localparam int CTL_SIGN = 6;
  localparam int CTL_SCAN = 5;
  localparam int CTL_MULTI_CHANNEL_SAMPLE = 4;
  localparam int CTL_RSVD = 3;
  localparam int CH_W = 3;
  localparam logic [7:0] CTL_WMASK = 8'hf7;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam int CFG_RES8 = 7;
  localparam int SEQ_W = 4;
  localparam logic [7:0] CFG_WMASK = 8'h8f;
  localparam logic [7:0] CFG_RST = 8'h04;
  localparam logic [SEQ_W-1:0] LEN_MAX = 4'h8;
  localparam int EV_W = 2;
  localparam int EV_SEQ = 0;
  localparam int EV_CONV = 1;
  localparam int STAT_CH_LSB = 4;
  localparam int STAT_BUSY = 7;
  localparam int RAW_W = 10;
  localparam int C8_W = 8;
  localparam int RES_W = 16;

  // ***********************************************************
  // Sequencer states
  // ***********************************************************
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_WAIT} adcsc_state_e;

  // Byte address of a register index
  function automatic logic [7:0] adcsc_addr(input logic [7:0] idx);
    adcsc_addr = {idx[5:0], 2'b00};
  endfunction

endpackage

/* verilog/adcsc_seq_if.sv */
`timescale 1ns/1ps
interface adcsc_seq_if;
  import adcsc_pkg::*;
  logic restart;
  logic [CH_W-1:0] first_chan;
  logic multi_channel_sample;
  logic scan;
  logic [SEQ_W-1:0] seq_len;
  logic busy;
  logic conv_ev;
  logic seq_ev;
  modport ctl (output restart, first_chan, multi_channel_sample, scan, seq_len,
    input busy, conv_ev, seq_ev);
  modport seq (input restart, first_chan, multi_channel_sample, scan, seq_len,
    output busy, conv_ev, seq_ev);
endinterface

/* verilog/adcsc_seq.sv */
`timescale 1ns/1ps
module adcsc_seq import adcsc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control side
  adcsc_seq_if.seq sif,
  // Converter side
  input wire logic conv_done,
  output logic conv_start_q,
  output logic [CH_W-1:0] chan_q
);

  adcsc_state_e state_q;
  logic [SEQ_W-1:0] cnt_q;
  logic [SEQ_W-1:0] len;
  logic last;
  logic cap;

  // Sequence length, zero or oversize meaning the full eight
  assign len = (sif.seq_len == '0 || sif.seq_len > LEN_MAX) ?
    LEN_MAX : sif.seq_len;
  assign last = (cnt_q == len - 4'h1);
  assign cap = (state_q == SEQ_WAIT) && conv_done && !sif.restart;
  assign sif.conv_ev = cap;
  assign sif.seq_ev = cap && last;
  assign sif.busy = (state_q != SEQ_IDLE);

  // Sequence state, count and channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SEQ_IDLE;
      cnt_q <= '0;
      chan_q <= '0;
    end else if (sif.restart) begin
      state_q <= SEQ_START;
      cnt_q <= '0;
      chan_q <= sif.first_chan;
    end else begin
      case (state_q)
        SEQ_IDLE: begin
          state_q <= SEQ_IDLE;
        end
        SEQ_START: begin
          state_q <= SEQ_WAIT;
        end
        SEQ_WAIT: begin
          if (conv_done) begin
            if (last) begin
              state_q <= sif.scan ? SEQ_START : SEQ_IDLE;
              cnt_q <= '0;
              chan_q <= sif.first_chan;
            end else begin
              state_q <= SEQ_START;
              cnt_q <= cnt_q + 4'h1;
              // Wraps from seven to zero by width
              if (sif.multi_channel_sample) begin
                chan_q <= chan_q + 3'h1;
              end else begin
                chan_q <= sif.first_chan;
              end
            end
          end
        end
        default: begin
          state_q <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Start strobe to the converter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= (state_q == SEQ_START) && !sif.restart;
    end
  end

  chan_wrap_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cap && !last && sif.multi_channel_sample |=> chan_q == $past(chan_q) + 3'h1)
    else $error("channel did not advance");
  single_chan_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_start_q && !sif.multi_channel_sample && !sif.restart && !$past(sif.restart, 2)
    |-> chan_q == sif.first_chan)
    else $error("single channel mode moved");

endmodule

/* verilog/adcsc_fmt.sv */
`timescale 1ns/1ps
module adcsc_fmt import adcsc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Format controls
  input wire logic cap,
  input wire logic [RAW_W-1:0] raw,
  input wire logic res8,
  input wire logic justify,
  input wire logic signed_sel,
  // Formatted result
  output logic [RES_W-1:0] result_q
);

  logic [C8_W-1:0] code8;
  logic [RES_W-1:0] word;

  assign code8 = raw[RAW_W-1:RAW_W-C8_W];

  // Place the code by width and justification
  always_comb begin
    case ({res8, justify})
      2'b10: word = {code8, {(RES_W-C8_W){1'b0}}};
      2'b11: word = {{(RES_W-C8_W){1'b0}}, code8};
      2'b00: word = {raw, {(RES_W-RAW_W){1'b0}}};
      2'b01: word = {{(RES_W-RAW_W){1'b0}}, raw};
      default: word = '0;
    endcase
    // Signed only when left justified
    if (signed_sel && !justify) begin
      word[RES_W-1] = ~word[RES_W-1];
    end
  end

  // Result register, loaded on each finished conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= '0;
    end else if (cap) begin
      result_q <= word;
    end
  end

  right_unsigned_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cap && justify |=> result_q[RES_W-1:RAW_W] == '0)
    else $error("right justified result not unsigned");
  sign_invert_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cap && !justify |=> result_q[RES_W-1] ==
    ($past(raw[RAW_W-1]) ^ $past(signed_sel)))
    else $error("sign bit wrong");
  left_ten_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cap && !justify && !res8 |=>
    result_q[RES_W-RAW_W-1:0] == '0)
    else $error("ten bit left result misplaced");

endmodule

/* testbench/adcsc_conv_model.sv */
`timescale 1ns/1ps
module adcsc_conv_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests from the sequencer
  input wire logic conv_start,
  input wire logic [2:0] conv_chan,
  input wire logic [7:0] dly,
  // Answer to the sequencer
  output logic conv_done,
  output logic [9:0] conv_data
);
  logic busy_q;
  logic [7:0] cnt_q;
  logic [2:0] ch_q;

  // ************************************************
  // One conversion at a time, answered after dly
  // ************************************************
  // A new start overrides a pending one, like an abort
  // Data toggles every cycle outside the done pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      ch_q <= 3'h0;
      conv_done <= 1'b0;
      conv_data <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        busy_q <= 1'b1;
        cnt_q <= dly;
        ch_q <= conv_chan;
      end else if (busy_q && cnt_q == 8'h00) begin
        busy_q <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= {ch_q, ~ch_q, ch_q, 1'b1};
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule

/* testbench/adcsc_tb_top.sv */
`timescale 1ns/1ps
module adcsc_tb_top import adcsc_pkg::*; ;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic conv_start, conv_done, irq;
  logic [7:0] paddr, dly;
  logic [31:0] pwdata, prdata, rd, ex;
  logic [2:0] conv_chan;
  logic [9:0] conv_data;
  logic [2:0] chq[$];
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  adcsc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_done(conv_done), .conv_data(conv_data), .irq(irq));
  adcsc_conv_model conv (.pclk(pclk), .presetn(presetn),
    .conv_start(conv_start), .conv_chan(conv_chan), .dly(dly),
    .conv_done(conv_done), .conv_data(conv_data));

  // ************************************************
  // Clock, channel monitor and timeout
  // ************************************************
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (conv_start === 1'b1) begin
      chq.push_back(conv_chan);
    end
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  // ************************************************
  // Helpers
  // ************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask

  // Poll status until the sequence complete flag is up
  task automatic wait_seq;
    rd = 32'h0;
    while (rd[0] !== 1'b1) apb(1'b0, IDX_STAT, 32'h0);
  endtask

  task automatic run(input logic [7:0] cfg, input logic [7:0] ctl);
    chq.delete();
    apb(1'b1, IDX_CFG, {24'h0, cfg});
    apb(1'b1, IDX_CTL, {24'h0, ctl});
    wait_seq();
  endtask

  // Compare the channels started against the expected walk
  task automatic chans(input logic [2:0] first, input int n,
                       input logic step);
    check(32'(chq.size()), 32'(n));
    for (int i = 0; i < n; i++) begin
      check({29'h0, chq[i]}, {29'h0, step ? first + i[2:0] : first});
    end
  endtask

  // Expected result word for a raw code and format bits
  function automatic logic [31:0] fmt(input logic r8, input logic j,
                                      input logic s, input logic [9:0] r);
    if (r8 && j) begin
      fmt = {24'h0, r[9:2]};
    end else if (r8) begin
      fmt = {16'h0, r[9] ^ s, r[8:2], 8'h00};
    end else if (j) begin
      fmt = {22'h0, r};
    end else begin
      fmt = {16'h0, r[9] ^ s, r[8:0], 6'h00};
    end
  endfunction

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    dly = 8'h02;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(IDX_CTL, 32'h00);
    rdc(IDX_CFG, 32'h04);
    apb(1'b0, 8'h3f, 32'h0);
    check({31'h0, err}, 32'h1);
    // Reserved bit ignored on write
    apb(1'b1, IDX_CTL, 32'hdf);
    rdc(IDX_CTL, 32'hd7);
    wait_seq();
    run(8'h03, 8'h05);
    chans(3'h5, 3, 1'b0);
    run(8'h04, 8'h16);
    chans(3'h6, 4, 1'b1);
    // Every format, each on its own channel
    for (int i = 0; i < 8; i++) begin
      run({i[2], 7'h01}, {i[1], i[0], 3'b000, i[2:0]});
      apb(1'b0, IDX_RES, 32'h0);
      ex = fmt(i[2], i[1], i[0], {i[2:0], ~i[2:0], i[2:0], 1'b1});
      check(rd, ex);
    end
    // Rewrite during a slow conversion, four conversions a sequence
    apb(1'b1, IDX_CFG, 32'h04);
    dly <= 8'd40;
    chq.delete();
    apb(1'b1, IDX_CTL, 32'h10);
    while (chq.size() == 0) @(posedge pclk);
    rdc(IDX_CTL, 32'h10);
    apb(1'b0, IDX_STAT, 32'h0);
    check({31'h0, rd[0]}, 32'h0);
    dly <= 8'h02;
    apb(1'b1, IDX_CTL, 32'h13);
    wait_seq();
    check({29'h0, chq.pop_front()}, 32'h0);
    chans(3'h3, 4, 1'b1);
    // Scan keeps going, single stops
    chq.delete();
    apb(1'b1, IDX_CFG, 32'h01);
    apb(1'b1, IDX_CTL, 32'h22);
    repeat (60) @(posedge pclk);
    check({31'h0, chq.size() >= 3}, 32'h1);
    apb(1'b1, IDX_CTL, 32'h02);
    wait_seq();
    chq.delete();
    repeat (20) @(posedge pclk);
    check(32'(chq.size()), 32'h0);
    // Interrupt raised, cleared and masked
    apb(1'b1, IDX_IEN, 32'h01);
    run(8'h01, 8'h01);
    check(rd, 32'h13);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, IDX_ICLR, 32'h01);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, IDX_IEN, 32'h00);
    run(8'h01, 8'h01);
    check({31'h0, irq}, 32'h0);
    finish_test();
  end
endmodule
